// [dic_consts.svh]
/*
 * constants for the dsp interrupt and idle controller: register offsets,
 * field positions, vectors, reset values and timing counts.
 * assumes inclusion by bare name from the design module and the testbench.
 */
`ifndef DIC_CONSTS_SVH
`define DIC_CONSTS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define DIC_ADDR_MASK 4'h0
`define DIC_ADDR_CTRL 4'h1
`define DIC_ADDR_FORCE_CLEAR 4'h2
`define DIC_ADDR_STATUS 4'h3
`define DIC_ADDR_PENDING 4'h4
`define DIC_ADDR_VECTOR 4'h5

// ----------------------------------------
// control register fields
// ----------------------------------------
`define DIC_CTRL_EDGE_SP0 0
`define DIC_CTRL_EDGE_SP1 1
`define DIC_CTRL_EDGE_EXTA 2
`define DIC_CTRL_NEST 4
`define DIC_CTRL_SP_B_IRQ 5
`define DIC_CTRL_XTAL_STOP 6
`define DIC_CTRL_RESET 16'h0000

// ----------------------------------------
// force/clear register fields
// ----------------------------------------
`define DIC_FC_FORCE_LSB 0
`define DIC_FC_CLEAR_LSB 8
`define DIC_FC_PWD_FORCE 15

// ----------------------------------------
// vectors and reset values
// ----------------------------------------
`define DIC_VEC_RESET 14'h0000
`define DIC_VEC_PWD 14'h002C
`define DIC_VEC_BASE 14'h0004
`define DIC_MASK_RESET 10'h000

// ----------------------------------------
// timing and stack depth
// ----------------------------------------
`define DIC_CLK_NS 40
`define DIC_WAKE_CLKS 100
`define DIC_XTAL_CLKS 4096
`define DIC_STACK_DEPTH 12

`endif

// [dic_ctrl.sv]
/*
 * dsp interrupt controller with power-down and idle wake-up control.
 * assumes one processor clock, a synchronous reset, pins from outside the
 * clock domain and a sequencer that acknowledges each vector it takes.
 */
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`include "dic_consts.svh"

// Operation
// - eleven sources plus reset: pins, timer, byte dma, serial ports, software, power-down.
// - reset vectors 0x0000, power-down 0x002C, others 0x0004..0x0028, timer lowest.
// - every level maskable except power-down and reset.
// - request a and both serial-pin requests selectable level or edge.
// - pending requests gated by mask; highest priority remaining is chosen.
// - nested or sequential handling chosen in the control register.
// - all interrupts blocked one cycle after a mask register write.
// - edge request pin always edge-sensitive, settable and clearable by software.
// - both level request pins are level-sensitive only.
// - write-only force/clear register sets or clears pending requests; reads zero.
// - taking an interrupt pushes status onto a twelve-deep stack.
// - global enable and disable gate all servicing, power-down included.
// - global servicing enable is set after reset.
// - reconfigured serial port b pins give two extra external interrupts.
// - power-down starts from the request pin or the software force bit.
// - power-down interrupt is edge-sensitive and nonmaskable; handler chooses to sleep.
// - acknowledge output shows power-down entered; reset ends power-down.
// - resume 100 clocks after power-down, or 4096 if the oscillator stopped.
// - idle stalls until an unmasked interrupt, then resumes after the idle.
// - slow idle divides internal, serial, output and timer clocks by 32..128.
// - in slow idle, wake-up may take up to n processor cycles.
// - shared flag pins raise interrupts whether driven outside or by own flag.
module dic_ctrl
    import dic_pkg::*;
#(
    parameter int XTAL_CLKS = `DIC_XTAL_CLKS,
    parameter int WAKE_CLKS = `DIC_WAKE_CLKS
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic ext_request_a_n,
    input wire logic level_request_0_n,
    input wire logic level_request_1_n,
    input wire logic edge_request_n,
    input wire logic [3:0] prog_flag_out,
    input wire logic [3:0] prog_flag_oe_n,
    input wire logic serial_pin_request_0_n,
    input wire logic serial_pin_request_1_n,
    input wire logic powerdown_request_pin_n,
    input wire logic sp_a_tx_int,
    input wire logic sp_a_rx_int,
    input wire logic sp_b_tx_int,
    input wire logic sp_b_rx_int,
    input wire logic byte_dma_int,
    input wire logic timer_int,
    input wire logic global_int_enable_instr,
    input wire logic global_int_disable_instr,
    input wire logic idle_instr,
    input wire logic [1:0] idle_div_sel,
    input wire logic enter_powerdown,
    input wire logic return_instr,
    input wire logic [15:0] status_in,
    output logic [15:0] status_out,
    output logic int_take,
    output logic [13:0] int_vector,
    input wire logic int_ack,
    output logic stack_overflow,
    output logic core_stall,
    output logic [7:0] slow_div,
    output logic slow_clk_en,
    output logic powerdown_ack_pin
);
    localparam int NSRC = 10;
    localparam int WW = 13;

    // ----------------------------------------
    // pin synchronisers and flag loopback
    // ----------------------------------------
    logic [7:0] pin_meta_ff;
    logic [7:0] pin_sync_ff;
    logic [7:0] pin_prev_ff;
    wire [3:0] flag_pins;
    // pin reads own flag output where driven
    assign flag_pins[0] = prog_flag_oe_n[0] ? edge_request_n : prog_flag_out[0];
    assign flag_pins[1] = prog_flag_oe_n[1] ? level_request_0_n : prog_flag_out[1];
    assign flag_pins[2] = prog_flag_oe_n[2] ? level_request_1_n : prog_flag_out[2];
    assign flag_pins[3] = prog_flag_oe_n[3] ? ext_request_a_n : prog_flag_out[3];
    wire [7:0] pin_raw = {powerdown_request_pin_n, serial_pin_request_1_n, serial_pin_request_0_n,
                          flag_pins[3], flag_pins[2], flag_pins[1], flag_pins[0], 1'b1};
    wire [7:0] pin_act = ~pin_sync_ff;
    wire [7:0] pin_fall = pin_act & ~pin_prev_ff;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pin_meta_ff <= 8'hFF;
            pin_sync_ff <= 8'hFF;
            pin_prev_ff <= 8'h00;
        end else begin
            pin_meta_ff <= pin_raw;
            pin_sync_ff <= pin_meta_ff;
            pin_prev_ff <= ~pin_sync_ff;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [NSRC-1:0] mask_ff;
    logic [15:0] ctrl_ff;
    logic gie_ff;
    logic mask_block_ff;
    logic [NSRC-1:0] edge_pend_ff;
    logic pwd_pend_ff;
    wire wr_mask = reg_wr && reg_addr == `DIC_ADDR_MASK;
    wire wr_ctrl = reg_wr && reg_addr == `DIC_ADDR_CTRL;
    wire wr_fc = reg_wr && reg_addr == `DIC_ADDR_FORCE_CLEAR;
    wire nest_en = ctrl_ff[`DIC_CTRL_NEST];
    wire sp_b_pins = ctrl_ff[`DIC_CTRL_SP_B_IRQ];

    // source order, priority high to low: a, l1, l0, sa tx, sa rx, e, dma, sb tx, sb rx, timer
    wire [NSRC-1:0] edge_mode;
    assign edge_mode[0] = ctrl_ff[`DIC_CTRL_EDGE_EXTA];
    assign edge_mode[1] = 1'b0;
    assign edge_mode[2] = 1'b0;
    assign edge_mode[3] = 1'b0;
    assign edge_mode[4] = 1'b0;
    assign edge_mode[5] = 1'b1;
    assign edge_mode[6] = 1'b0;
    assign edge_mode[7] = sp_b_pins & ctrl_ff[`DIC_CTRL_EDGE_SP1];
    assign edge_mode[8] = sp_b_pins & ctrl_ff[`DIC_CTRL_EDGE_SP0];
    assign edge_mode[9] = 1'b0;

    // serial port b pins replace its own sources when reconfigured
    wire sb_tx_lvl = sp_b_pins ? pin_act[6] : sp_b_tx_int;
    wire sb_rx_lvl = sp_b_pins ? pin_act[5] : sp_b_rx_int;
    wire [NSRC-1:0] src_level = {timer_int, sb_rx_lvl, sb_tx_lvl, byte_dma_int, pin_act[1],
                                 sp_a_rx_int, sp_a_tx_int, pin_act[2], pin_act[3], pin_act[4]};
    wire [NSRC-1:0] src_edge = {1'b0, sp_b_pins & pin_fall[5], sp_b_pins & pin_fall[6], 1'b0,
                                pin_fall[1], 2'b00, 2'b00, pin_fall[4]};
    wire [NSRC-1:0] fc_force = reg_wdata[`DIC_FC_FORCE_LSB +: NSRC] & edge_mode & {NSRC{wr_fc}};

    // ----------------------------------------
    // priority selection
    // ----------------------------------------
    logic [NSRC-1:0] svc_mask_ff;
    logic in_pwd_svc_ff;
    wire [NSRC-1:0] req_vec = (edge_pend_ff & edge_mode) | (src_level & ~edge_mode);
    wire [NSRC-1:0] masked = req_vec & mask_ff;
    wire allow = gie_ff && !mask_block_ff;

    function automatic logic [3:0] first_set(input logic [NSRC-1:0] v);
        logic [3:0] idx;
        idx = 4'd15;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction

    wire [3:0] pick = first_set(masked);
    wire [3:0] busy_top = first_set(svc_mask_ff);
    wire any_busy = (|svc_mask_ff) || in_pwd_svc_ff;
    // nested: only strictly higher priority preempts; sequential: nothing while busy
    wire lvl_ok = (pick != 4'd15) && (nest_en ? (!in_pwd_svc_ff && pick < busy_top) : !any_busy);
    wire pwd_ok = pwd_pend_ff && (nest_en || !any_busy) && !in_pwd_svc_ff;
    wire [13:0] lvl_vec = `DIC_VEC_BASE + {8'h00, pick, 2'b00};

    // ----------------------------------------
    // status stack
    // ----------------------------------------
    logic [15:0] stack_mem [`DIC_STACK_DEPTH];
    logic [3:0] sp_ff;
    logic [NSRC:0] svc_stack [`DIC_STACK_DEPTH];
    wire push = int_take && int_ack;
    wire pop = return_instr && sp_ff != 4'd0;
    wire [3:0] sp_top = sp_ff - 4'd1;
    assign stack_overflow = push && sp_ff == 4'(`DIC_STACK_DEPTH);
    assign status_out = stack_mem[sp_top];

    always_ff @(posedge ref_clk) begin
        if (push && !stack_overflow) begin
            stack_mem[sp_ff] <= status_in;
            svc_stack[sp_ff] <= {in_pwd_svc_ff, svc_mask_ff};
        end
    end

    // ----------------------------------------
    // power and idle state machine
    // ----------------------------------------
    dic_state_e state_ff;
    dic_state_e nxt_state;
    logic [WW-1:0] wait_ff;
    logic [WW-1:0] nxt_wait;
    logic [7:0] div_ff;
    logic [7:0] div_cnt_ff;
    wire [7:0] div_sel = 8'h10 << idle_div_sel;
    wire [WW-1:0] wake_len = ctrl_ff[`DIC_CTRL_XTAL_STOP] ? WW'(XTAL_CLKS) : WW'(WAKE_CLKS);
    wire any_int = lvl_ok | pwd_ok;
    wire slow_tick = div_cnt_ff == 8'h00;

    always_comb begin
        nxt_state = state_ff;
        nxt_wait = wait_ff;
        case (state_ff)
            DIC_RUN: begin
                if (enter_powerdown) begin
                    nxt_state = DIC_PWD;
                end else if (idle_instr) begin
                    nxt_state = DIC_IDLE;
                end
            end
            DIC_IDLE: begin
                // slow idle notices wake only on a divided tick
                if (any_int && (div_ff == 8'h01 || slow_tick)) begin
                    nxt_state = DIC_RUN;
                end
            end
            DIC_PWD: begin
                if (!pin_act[7] && !pwd_pend_ff) begin
                    nxt_state = DIC_WAKE;
                    nxt_wait = wake_len;
                end
            end
            DIC_WAKE: begin
                nxt_wait = wait_ff - WW'(1);
                if (wait_ff == WW'(1)) begin
                    nxt_state = DIC_RUN;
                end
            end
            default: nxt_state = DIC_RUN;
        endcase
    end

    assign core_stall = state_ff != DIC_RUN;
    assign powerdown_ack_pin = state_ff == DIC_PWD;
    assign slow_div = div_ff;
    assign slow_clk_en = div_ff == 8'h01 || slow_tick;
    assign int_take = state_ff == DIC_RUN && allow && any_int;
    assign int_vector = pwd_ok ? `DIC_VEC_PWD : lvl_vec;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_ff <= DIC_RUN;
            wait_ff <= '0;
            div_ff <= 8'h01;
            div_cnt_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            wait_ff <= nxt_wait;
            if (state_ff == DIC_RUN) begin
                div_ff <= idle_instr && idle_div_sel != 2'b00 ? div_sel : 8'h01;
                div_cnt_ff <= 8'h00;
            end else begin
                div_cnt_ff <= slow_tick ? div_ff - 8'h01 : div_cnt_ff - 8'h01;
            end
        end
    end

    // ----------------------------------------
    // pending, mask, control and service state
    // ----------------------------------------
    wire take_lvl = push && !pwd_ok;
    wire [NSRC-1:0] take_one = take_lvl ? NSRC'(1) << pick : '0;
    wire [NSRC-1:0] sw_clear = {2'b00, reg_wdata[`DIC_FC_CLEAR_LSB +: 8]} & edge_mode & {NSRC{wr_fc}};

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            mask_ff <= `DIC_MASK_RESET;
            ctrl_ff <= `DIC_CTRL_RESET;
            gie_ff <= 1'b1;
            mask_block_ff <= 1'b0;
            edge_pend_ff <= '0;
            pwd_pend_ff <= 1'b0;
            svc_mask_ff <= '0;
            in_pwd_svc_ff <= 1'b0;
            sp_ff <= 4'd0;
        end else begin
            if (wr_mask) begin
                mask_ff <= reg_wdata[NSRC-1:0];
            end
            mask_block_ff <= wr_mask;
            if (wr_ctrl) begin
                ctrl_ff <= reg_wdata;
            end
            if (global_int_enable_instr) begin
                gie_ff <= 1'b1;
            end else if (global_int_disable_instr) begin
                gie_ff <= 1'b0;
            end
            // set beats clear
            edge_pend_ff <= ((edge_pend_ff & ~sw_clear & ~take_one) | src_edge | fc_force) & edge_mode;
            if (pin_fall[7] || (wr_fc && reg_wdata[`DIC_FC_PWD_FORCE])) begin
                pwd_pend_ff <= 1'b1;
            end else if (push && pwd_ok) begin
                pwd_pend_ff <= 1'b0;
            end
            if (push && !stack_overflow) begin
                sp_ff <= sp_ff + 4'd1;
                svc_mask_ff <= take_one;
                in_pwd_svc_ff <= pwd_ok;
            end else if (pop) begin
                sp_ff <= sp_top;
                {in_pwd_svc_ff, svc_mask_ff} <= svc_stack[sp_top];
            end
        end
    end

    // ----------------------------------------
    // register read port
    // ----------------------------------------
    wire [15:0] rd_mux = reg_addr == `DIC_ADDR_MASK ? 16'(mask_ff) :
                         reg_addr == `DIC_ADDR_CTRL ? ctrl_ff :
                         reg_addr == `DIC_ADDR_STATUS ? {10'h000, sp_ff, gie_ff, powerdown_ack_pin} :
                         reg_addr == `DIC_ADDR_PENDING ? {5'h00, pwd_pend_ff, req_vec} :
                         reg_addr == `DIC_ADDR_VECTOR ? {2'b00, int_vector} : 16'h0000;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 16'h0000;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    mask_block_one_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wr_mask |=> !int_take) else $error("interrupt taken right after mask write");
    gie_gate_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !gie_ff |-> !int_take) else $error("interrupt taken while globally disabled");
    mask_gate_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (int_take && !pwd_ok) |-> mask_ff[pick] && req_vec[pick]) else $error("masked source taken");
    pwd_vector_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (int_take && pwd_ok) |-> int_vector == 14'h002C) else $error("wrong power-down vector");
    timer_vector_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (int_take && !pwd_ok && pick == 4'd9) |-> int_vector == 14'h0028) else $error("wrong timer vector");
    pwd_ack_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_ff == DIC_RUN && enter_powerdown) |=> powerdown_ack_pin) else $error("no power-down ack");
    wake_wait_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_ff == DIC_WAKE && wait_ff == 13'd2) |=> core_stall ##1 !core_stall)
        else $error("wake-up count wrong");
    edge_latch_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (src_edge[5] && !take_one[5]) |=> edge_pend_ff[5]) else $error("edge request lost");
    gie_reset_a: assert property (@(posedge ref_clk)
        sys_rst |=> gie_ff) else $error("global enable not set by reset");
endmodule

// [dic_pkg.sv]
/*
 * types for the dsp interrupt and idle controller.
 * assumes nothing beyond the constants header.
 */
package dic_pkg;
    typedef enum logic [1:0] {
        DIC_RUN,
        DIC_IDLE,
        DIC_PWD,
        DIC_WAKE
    } dic_state_e;
endpackage

// [dic_seq_model.sv]
/*
 * sequencer model: acknowledges each vector and runs a handler of run_len
 * cycles before popping with a return; nests when the controller preempts.
 * assumes dic_ctrl request and acknowledge timing on ref_clk.
 */
`timescale 1ns/100ps
module dic_seq_model (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic int_take,
    input wire logic [7:0] run_len,
    input wire logic [1:0] ack_wait,
    output logic int_ack,
    output logic return_instr,
    output logic [3:0] depth
);
    logic [7:0] cnt;
    logic [1:0] wait_cnt;
    always_ff @(posedge ref_clk) begin
        int_ack <= 1'b0;
        return_instr <= 1'b0;
        if (sys_rst) begin
            depth <= 4'h0;
            cnt <= 8'h00;
            wait_cnt <= 2'b00;
        end else if (int_take && int_ack) begin
            depth <= depth + 4'h1;
            cnt <= 8'h00;
        end else if (int_take && !int_ack && wait_cnt == ack_wait) begin
            int_ack <= 1'b1;
            wait_cnt <= 2'b00;
        end else begin
            if (int_take && !int_ack)
                wait_cnt <= wait_cnt + 2'b01;
            if (depth != 4'h0 && cnt == run_len) begin
                return_instr <= 1'b1;
                depth <= depth - 4'h1;
                cnt <= 8'h00;
            end else if (depth != 4'h0)
                cnt <= cnt + 8'h01;
        end
    end
endmodule

// [testbench.sv]
/*
 * self-checking bench for dic_ctrl driving pins, sources and registers.
 * assumes the register map, fields and vectors of dic_consts.svh.
 */
`timescale 1ns/100ps
`include "dic_consts.svh"
module testbench;
    localparam int WAKE = 10;
    localparam int XTAL = 20;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [11:0] req = 12'h000;
    logic [3:0] flag_oe_n = 4'hF;
    logic [3:0] flag_out = 4'h0;
    logic pwd_n = 1'b1;
    logic gie_on = 1'b0;
    logic gie_off = 1'b0;
    logic idle_go = 1'b0;
    logic pwd_go = 1'b0;
    logic [1:0] div_sel = 2'b00;
    logic [15:0] stat_in = 16'h0000;
    logic [7:0] run_len = 8'h04;
    logic [1:0] ack_wait = 2'b00;
    logic [15:0] reg_rdata, status_out;
    logic int_take, int_ack, ret, ovf, stall, slow_en, pwd_ack;
    logic [13:0] vec;
    logic [7:0] slow_div;
    logic [3:0] depth;
    logic rd_pend = 1'b0;
    logic [5:0] bits;
    logic [15:0] rq[$];
    logic [13:0] vq[$];
    logic [31:0] rng = 32'd61402;
    int fail_count = 0;
    int checks = 0;
    int n;
    int unsigned takes = 0;
    logic [3:0] src_of [12] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h8, 4'h7, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9};

    always #20 ref_clk = ~ref_clk;

    dic_ctrl #(.XTAL_CLKS(XTAL), .WAKE_CLKS(WAKE)) dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ext_request_a_n(~req[0]), .level_request_1_n(~req[1]), .level_request_0_n(~req[2]),
        .edge_request_n(~req[3]), .prog_flag_out(flag_out), .prog_flag_oe_n(flag_oe_n),
        .serial_pin_request_0_n(~req[4]), .serial_pin_request_1_n(~req[5]), .powerdown_request_pin_n(pwd_n),
        .sp_a_tx_int(req[6]), .sp_a_rx_int(req[7]), .byte_dma_int(req[8]), .sp_b_tx_int(req[9]),
        .sp_b_rx_int(req[10]), .timer_int(req[11]), .global_int_enable_instr(gie_on),
        .global_int_disable_instr(gie_off), .idle_instr(idle_go), .idle_div_sel(div_sel),
        .enter_powerdown(pwd_go), .return_instr(ret), .status_in(stat_in), .status_out(status_out),
        .int_take(int_take), .int_vector(vec), .int_ack(int_ack), .stack_overflow(ovf),
        .core_stall(stall), .slow_div(slow_div), .slow_clk_en(slow_en), .powerdown_ack_pin(pwd_ack));

    dic_seq_model seq_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .int_take(int_take), .run_len(run_len),
        .ack_wait(ack_wait), .int_ack(int_ack), .return_instr(ret), .depth(depth));

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction

    function automatic logic [13:0] vec_of(input logic [3:0] s);
        return `DIC_VEC_BASE + {8'h00, s, 2'b00};
    endfunction

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        rq.push_back(exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    endtask

    task automatic drain();
        int i;
        i = 0;
        while ((vq.size() != 0 || depth !== 4'h0) && i < 600) begin
            @(posedge ref_clk);
            i++;
        end
        check("drain", 16'(i < 600), 16'h0001);
        @(posedge ref_clk);
    endtask

    task automatic gie_pulse(input logic on);
        gie_on <= on;
        gie_off <= !on;
        @(posedge ref_clk);
        gie_on <= 1'b0;
        gie_off <= 1'b0;
    endtask

    task automatic wait_take(input int unsigned t0);
        for (int i = 0; i < 100 && takes == t0; i++)
            @(posedge ref_clk);
    endtask

    // ----------------------------------------
    // result watcher
    // ----------------------------------------
    always @(posedge ref_clk) begin
        rd_pend <= reg_rd;
        if (rd_pend)
            check("reg_rdata", reg_rdata, (rq.size() != 0) ? rq.pop_front() : 16'hFFFF);
        if (int_take === 1'b1 && int_ack === 1'b1) begin
            takes++;
            check("int_vector", {2'b00, vec}, (vq.size() != 0) ? {2'b00, vq.pop_front()} : 16'hFFFF);
            for (int k = 0; k < 12; k++)
                if (vec_of(src_of[k]) == vec)
                    req[k] <= 1'b0;
        end
    end

    initial begin
        #(40 * 60000);
        fail_count++;
        test_done();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(`DIC_ADDR_MASK, 16'h0000);
        rd(`DIC_ADDR_CTRL, 16'h0000);
        rd(4'hE, 16'h0000);
        rng = xs(rng);
        wr(`DIC_ADDR_MASK, rng[15:0]);
        wr(4'hE, 16'hFFFF);
        rd(`DIC_ADDR_MASK, {6'h00, rng[9:0]});
        wr(`DIC_ADDR_MASK, 16'h03FF);
        for (int k = 0; k < 12; k++) begin
            wr(`DIC_ADDR_CTRL, (k == 4 || k == 5) ? 16'h0020 : 16'h0000);
            vq.push_back(vec_of(src_of[k]));
            req[k] <= 1'b1;
            drain();
        end
        wr(`DIC_ADDR_CTRL, 16'h0027);
        wr(`DIC_ADDR_MASK, 16'h0000);
        req[0] <= 1'b1;
        req[3] <= 1'b1;
        req[4] <= 1'b1;
        repeat (4) @(posedge ref_clk);
        req <= 12'h000;
        repeat (4) @(posedge ref_clk);
        rd(`DIC_ADDR_PENDING, 16'h0121);
        wr(`DIC_ADDR_FORCE_CLEAR, 16'h2100);
        rd(`DIC_ADDR_PENDING, 16'h0100);
        wr(`DIC_ADDR_FORCE_CLEAR, 16'h0020);
        rd(`DIC_ADDR_PENDING, 16'h0120);
        rd(`DIC_ADDR_FORCE_CLEAR, 16'h0000);
        vq.push_back(14'h0018);
        vq.push_back(14'h0024);
        wr(`DIC_ADDR_MASK, 16'h0120);
        drain();
        rd(`DIC_ADDR_PENDING, 16'h0000);
        wr(`DIC_ADDR_CTRL, 16'h0000);
        wr(`DIC_ADDR_MASK, 16'h03FF);
        for (int r = 0; r < 8; r++) begin
            rng = xs(rng);
            bits = (r == 0) ? 6'h3F : (rng[5:0] | 6'h01);
            ack_wait <= rng[17:16];
            for (int k = 0; k < 6; k++)
                if (bits[k])
                    vq.push_back(vec_of(src_of[k + 6]));
            req[11:6] <= bits;
            drain();
        end
        ack_wait <= 2'b00;
        wr(`DIC_ADDR_MASK, 16'h01FF);
        req[11] <= 1'b1;
        repeat (6) @(posedge ref_clk);
        check("int_take masked", int_take, 16'h0000);
        vq.push_back(14'h0028);
        wr(`DIC_ADDR_MASK, 16'h03FF);
        #1 check("int_take after mask write", int_take, 16'h0000);
        drain();
        gie_pulse(1'b0);
        req[8] <= 1'b1;
        repeat (8) @(posedge ref_clk);
        check("int_take disabled", int_take, 16'h0000);
        vq.push_back(14'h001C);
        gie_pulse(1'b1);
        drain();
        run_len <= {5'h00, rng[2:0]} | 8'h28;
        for (int m = 0; m < 2; m++) begin
            wr(`DIC_ADDR_CTRL, m ? 16'h0010 : 16'h0000);
            rng = xs(rng);
            stat_in <= rng[15:0];
            vq.push_back(14'h0028);
            vq.push_back(14'h001C);
            n = takes;
            req[11] <= 1'b1;
            repeat (6) @(posedge ref_clk);
            check("status_out", status_out, rng[15:0]);
            req[8] <= 1'b1;
            repeat (8) @(posedge ref_clk);
            check("nested takes", 16'(takes - n), m ? 16'h0002 : 16'h0001);
            drain();
        end
        vq.push_back(14'h000C);
        n = takes;
        rng = xs(rng);
        flag_out <= rng[3:0] & 4'hD;
        flag_oe_n <= ~(rng[3:0] | 4'h2);
        wait_take(n);
        flag_oe_n <= 4'hF;
        drain();
        run_len <= 8'h04;
        for (int s = 0; s < 4; s++) begin
            div_sel <= s[1:0];
            idle_go <= 1'b1;
            @(posedge ref_clk);
            idle_go <= 1'b0;
            @(posedge ref_clk);
            #1 check("core_stall idle", stall, 16'h0001);
            if (s != 0)
                check("slow_div", slow_div, 16'd16 << s);
            vq.push_back(14'h0028);
            req[11] <= 1'b1;
            drain();
            check("core_stall woken", stall, 16'h0000);
        end
        wr(`DIC_ADDR_MASK, 16'h0000);
        for (int x = 0; x < 3; x++) begin
            wr(`DIC_ADDR_CTRL, (x == 1) ? 16'h0040 : 16'h0000);
            vq.push_back(14'h002C);
            n = takes;
            pwd_n <= (x == 1);
            if (x == 1)
                wr(`DIC_ADDR_FORCE_CLEAR, 16'h8000);
            wait_take(n);
            pwd_go <= 1'b1;
            @(posedge ref_clk);
            pwd_go <= 1'b0;
            #1 check("powerdown_ack_pin", pwd_ack, 16'h0001);
            pwd_n <= 1'b1;
            if (x == 2) begin
                sys_rst <= 1'b1;
                repeat (2) @(posedge ref_clk);
                #1 check("powerdown_ack_pin reset", pwd_ack, 16'h0000);
                sys_rst <= 1'b0;
            end else begin
                for (int i = 0; i < 60 && pwd_ack !== 1'b0; i++)
                    @(posedge ref_clk);
                n = 0;
                while (stall !== 1'b0 && n < 200) begin
                    @(posedge ref_clk);
                    n++;
                end
                n = n - ((x == 1) ? XTAL : WAKE);
                check("wake cycles", 16'(n >= -2 && n <= 4), 16'h0001);
                drain();
            end
        end
        rd(`DIC_ADDR_MASK, 16'h0000);
        wr(`DIC_ADDR_MASK, 16'h03FF);
        vq.push_back(14'h0028);
        req[11] <= 1'b1;
        drain();
        test_done();
    end
endmodule
